// file: hw/uartm_pkg.sv
// Constants, register map and state codes of the UART channel.
package uartm_pkg;
  // Register byte addresses.
  localparam logic [15:0] ADDR_PIN_DIR   = 16'hff2b;
  localparam logic [15:0] ADDR_PIN_LATCH = 16'hff0b;
  localparam logic [15:0] ADDR_MODE      = 16'hff50;
  localparam logic [15:0] ADDR_RXBUF     = 16'hff52;
  localparam logic [15:0] ADDR_RXERR     = 16'hff53;
  localparam logic [15:0] ADDR_TXSTAT    = 16'hff55;
  localparam logic [15:0] ADDR_CKSEL     = 16'hff56;
  localparam logic [15:0] ADDR_BAUD      = 16'hff57;
  localparam logic [15:0] ADDR_CTRL      = 16'hff58;
  localparam logic [15:0] ADDR_TXBUF     = 16'hff59;
  // Reset values and the fixed high nibble of the direction register.
  localparam logic [3:0]  RST_PIN_DIR    = 4'hf;
  localparam logic [3:0]  PIN_DIR_HI     = 4'hf;
  localparam logic [3:0]  RST_PIN_LATCH  = 4'h0;
  localparam logic [7:0]  RST_MODE       = 8'h01;
  localparam logic [2:0]  RST_CKSEL      = 3'h0;
  localparam logic [7:0]  RST_BAUD       = 8'hff;
  localparam logic [1:0]  RST_CTRL       = 2'h0;
  localparam logic [7:0]  RST_RXBUF      = 8'hff;
  // Mode register fields.
  localparam int MODE_ISRM  = 0;
  localparam int MODE_SL    = 1;
  localparam int MODE_CL    = 2;
  localparam int MODE_PS_LO = 3;
  localparam int MODE_PS_HI = 4;
  localparam int MODE_RXE   = 5;
  localparam int MODE_TXE   = 6;
  localparam int MODE_PWR   = 7;
  // Control register fields.
  localparam int CTRL_TXLV  = 0;
  localparam int CTRL_DIR   = 1;
  // Pin positions, error and status bits.
  localparam int TX_PIN     = 2;
  localparam int RX_PIN     = 3;
  localparam int ERR_OVR    = 0;
  localparam int ERR_FRM    = 1;
  localparam int ERR_PAR    = 2;
  localparam int ST_BUSY    = 0;
  localparam int ST_FULL    = 1;
  // Parity selections.
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // Character lengths in bits and the transmit buffer's full count.
  localparam logic [3:0] NB8 = 4'h8;
  localparam logic [3:0] NB7 = 4'h7;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h3,
    ST_PAR   = 3'h2,
    ST_STOP  = 3'h6
  } uartm_st_e;
endpackage

// file: hw/uartm_fifo2.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module uartm_fifo2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = cnt_q != uartm_pkg::FIFO_FULL;
  assign out_valid = cnt_q != 2'h0;
  assign out_data  = mem_q[rp_q];

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset || (ce && flush)) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else if (ce) begin
      wp_q  <= wp_q ^ push;
      rp_q  <= rp_q ^ pop;
      cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
    end
  end
endmodule
`default_nettype wire

// file: hw/uartm_top.sv
// UART channel with baud generator, frame engines and pin direction logic.
`timescale 1ns/1ns
`default_nettype none
// Function
// R01: Each character is one data byte sent or received after a start bit.
// R02: Transmitter and receiver run at the same time, full duplex.
// R03: The channel has its own baud generator with a selectable bit rate.
// R04: Software writes clock select, divisor, mode bits 0-4 and control bits 0-1 before power on.
// R05: Software then sets mode bit 7 to power the channel.
// R06: With power on, mode bit 6 enables transmission.
// R07: With power on, mode bit 5 enables reception.
// R08: With transmission enabled, a transmit buffer write starts sending that character.
// R09: For serial output software clears the pin's direction bit and sets its latch to 1.
// R10: For serial input software sets the pin's direction bit to 1, latch ignored.
// R11: Direction bits 0-3 select output at 0 and input at 1, bits 7-4 read 1, reset gives all ones.
// R12: The direction register takes single-bit and whole-byte writes.
// R13: A frame ends with the chosen number of idle-level stop bits, parity sitting before them.
module uartm_top (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [15:0] bus_addr,
  input  wire logic [7:0]  bus_wdata,
  input  wire logic [7:0]  bus_wmask,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic [7:0]       bus_rdata,
  input  wire logic [3:0]  pin_in,
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe
);
  logic [7:0]       mode_q;
  logic [2:0]       cks_q;
  logic [7:0]       baud_q;
  logic [1:0]       ctrl_q;
  logic [3:0]       dir_q;
  logic [3:0]       latch_q;
  logic [2:0]       err_q;
  logic [7:0]       rxd_q;
  logic             rxf_q;
  logic [3:0]       sync1_q;
  logic [3:0]       sync2_q;
  logic [6:0]       pre_q;
  uartm_pkg::uartm_st_e tx_st_q;
  uartm_pkg::uartm_st_e rx_st_q;
  logic [7:0]       tx_cnt_q;
  logic [7:0]       rx_cnt_q;
  logic [3:0]       tx_bit_q;
  logic [3:0]       rx_bit_q;
  logic [7:0]       tx_sh_q;
  logic [7:0]       rx_sh_q;
  logic             tx_line_q;
  logic             tx_par_q;
  logic             tx_sb_q;
  logic             rx_pbad_q;
  logic             fifo_in_ready;
  logic             fifo_out_valid;
  logic [7:0]       fifo_out_data;

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  // Puts the character into line order; the same mapping undoes it on receive.
  function automatic logic [7:0] order(input logic [7:0] d, input logic msb, input logic nb8);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) begin
      r[i] = d[7-i];
    end
    order = !msb ? d : (nb8 ? r : {1'b0, r[7:1]});
  endfunction

  function automatic logic par_bit(input logic [7:0] d, input logic nb8, input logic [1:0] sel);
    logic x;
    x = nb8 ? ^d : ^d[6:0];
    par_bit = (sel == uartm_pkg::PAR_ODD) ? ~x : ((sel == uartm_pkg::PAR_EVEN) ? x : 1'b0);
  endfunction

  wire       wr_mode  = bus_wr && bus_addr == uartm_pkg::ADDR_MODE;
  wire       wr_cks   = bus_wr && bus_addr == uartm_pkg::ADDR_CKSEL;
  wire       wr_baud  = bus_wr && bus_addr == uartm_pkg::ADDR_BAUD;
  wire       wr_ctrl  = bus_wr && bus_addr == uartm_pkg::ADDR_CTRL;
  wire       wr_dir   = bus_wr && bus_addr == uartm_pkg::ADDR_PIN_DIR;
  wire       wr_latch = bus_wr && bus_addr == uartm_pkg::ADDR_PIN_LATCH;
  wire       wr_txbuf = bus_wr && bus_addr == uartm_pkg::ADDR_TXBUF;
  wire       rd_rxbuf = bus_rd && bus_addr == uartm_pkg::ADDR_RXBUF;
  wire       rd_err   = bus_rd && bus_addr == uartm_pkg::ADDR_RXERR;
  wire       power    = mode_q[uartm_pkg::MODE_PWR];
  wire       tx_on    = power && mode_q[uartm_pkg::MODE_TXE];  // see R06
  wire       rx_on    = power && mode_q[uartm_pkg::MODE_RXE];  // see R07
  wire       nb8      = mode_q[uartm_pkg::MODE_CL];
  wire [3:0] nbits    = nb8 ? uartm_pkg::NB8 : uartm_pkg::NB7;
  wire [1:0] psel     = mode_q[uartm_pkg::MODE_PS_HI:uartm_pkg::MODE_PS_LO];
  wire       par_en   = psel != uartm_pkg::PAR_NONE;
  wire       two_stop = mode_q[uartm_pkg::MODE_SL];
  wire       msb_1st  = ctrl_q[uartm_pkg::CTRL_DIR];
  wire       rin      = sync2_q[uartm_pkg::RX_PIN];

  // Baud generator: a 2^n prescaler followed by a per-direction divisor count.
  wire [6:0] pre_lim  = 7'((8'h01 << cks_q) - 8'h01);              // see R03
  wire       pre_tick = pre_q == pre_lim;
  wire [7:0] baud_m1  = baud_q - 8'h01;
  wire [7:0] half_m1  = {1'b0, baud_q[7:1]} - 8'h01;
  wire       tx_be    = pre_tick && tx_cnt_q == baud_m1;
  wire [7:0] rx_lim   = (rx_st_q == uartm_pkg::ST_START) ? half_m1 : baud_m1;
  wire       rx_be    = pre_tick && rx_cnt_q == rx_lim;

  wire       tx_pop   = fifo_out_valid && tx_on && tx_st_q == uartm_pkg::ST_IDLE;  // see R08
  wire [7:0] rx_word  = nb8 ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  wire       rx_done  = rx_st_q == uartm_pkg::ST_STOP && rx_be;
  wire       rx_frm   = rx_done && !rin;
  wire       rx_bad   = rx_frm || (rx_done && rx_pbad_q);
  wire       rx_store = rx_done && (!rx_bad || mode_q[uartm_pkg::MODE_ISRM]);
  wire       rx_ovr   = rx_store && rxf_q && !rd_rxbuf;
  wire [2:0] err_set  = {rx_done && rx_pbad_q, rx_frm, rx_ovr};
  wire       tx_ser   = tx_on ? tx_line_q ^ ctrl_q[uartm_pkg::CTRL_TXLV] : 1'b1;

  wire [7:0] rd_val =
    (bus_addr == uartm_pkg::ADDR_MODE)      ? mode_q :
    (bus_addr == uartm_pkg::ADDR_CKSEL)     ? {5'h00, cks_q} :
    (bus_addr == uartm_pkg::ADDR_BAUD)      ? baud_q :
    (bus_addr == uartm_pkg::ADDR_CTRL)      ? {6'h00, ctrl_q} :
    (bus_addr == uartm_pkg::ADDR_PIN_DIR)   ? {uartm_pkg::PIN_DIR_HI, dir_q} :  // see R11
    (bus_addr == uartm_pkg::ADDR_PIN_LATCH) ? {4'h0, latch_q} :
    (bus_addr == uartm_pkg::ADDR_RXBUF)     ? rxd_q :
    (bus_addr == uartm_pkg::ADDR_RXERR)     ? {5'h00, err_q} :
    (bus_addr == uartm_pkg::ADDR_TXSTAT)    ? {6'h00, !fifo_in_ready, tx_st_q != uartm_pkg::ST_IDLE} :
    8'h00;

  uartm_fifo2 #(.W(8)) u_txfifo (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .flush     (!tx_on),
    .in_valid  (wr_txbuf && tx_on),
    .in_ready  (fifo_in_ready),
    .in_data   (bus_wdata),
    .out_valid (fifo_out_valid),
    .out_ready (tx_pop),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q  <= uartm_pkg::RST_MODE;
      cks_q   <= uartm_pkg::RST_CKSEL;
      baud_q  <= uartm_pkg::RST_BAUD;
      ctrl_q  <= uartm_pkg::RST_CTRL;
      dir_q   <= uartm_pkg::RST_PIN_DIR;
      latch_q <= uartm_pkg::RST_PIN_LATCH;
    end else if (ce) begin
      if (wr_mode) mode_q <= merge(mode_q, bus_wdata, bus_wmask);
      if (wr_cks) cks_q <= 3'(merge({5'h00, cks_q}, bus_wdata, bus_wmask));
      if (wr_baud) baud_q <= merge(baud_q, bus_wdata, bus_wmask);
      if (wr_ctrl) ctrl_q <= 2'(merge({6'h00, ctrl_q}, bus_wdata, bus_wmask));
      if (wr_dir) dir_q <= 4'(merge({4'h0, dir_q}, bus_wdata, bus_wmask));  // see R12
      if (wr_latch) latch_q <= 4'(merge({4'h0, latch_q}, bus_wdata, bus_wmask));
    end
  end

  // Pin outputs; a direction bit of 1 turns the buffer off.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_oe    <= 4'h0;
      pin_out   <= 4'h0;
      bus_rdata <= 8'h00;
      sync1_q   <= 4'hf;
      sync2_q   <= 4'hf;
      pre_q     <= 7'h00;
    end else if (ce) begin
      pin_oe    <= ~dir_q;  // see R11
      pin_out   <= latch_q & ~(4'h1 << uartm_pkg::TX_PIN) | ({3'h0, latch_q[uartm_pkg::TX_PIN] & tx_ser} << uartm_pkg::TX_PIN);  // see R09
      bus_rdata <= bus_rd ? rd_val : 8'h00;
      sync1_q   <= pin_in;
      sync2_q   <= sync1_q;  // see R10
      pre_q     <= (pre_tick || !power) ? 7'h00 : 7'(pre_q + 7'h01);  // see R05
    end
  end

  // Receive holding register and sticky errors; a set beats a read clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      rxd_q <= uartm_pkg::RST_RXBUF;
      rxf_q <= 1'b0;
      err_q <= 3'h0;
    end else if (ce) begin
      if (rx_store) rxd_q <= order(rx_word, msb_1st, nb8);  // see R01
      rxf_q <= rx_store || (rxf_q && !rd_rxbuf);
      err_q <= (rd_err ? 3'h0 : err_q) | err_set;
    end
  end

  // Transmit engine: start, data, optional parity, stop bits.
  always_ff @(posedge clk) begin
    if (reset || (ce && !tx_on)) begin
      tx_st_q   <= uartm_pkg::ST_IDLE;
      tx_cnt_q  <= 8'h00;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 8'h00;
      tx_line_q <= 1'b1;
      tx_par_q  <= 1'b0;
      tx_sb_q   <= 1'b0;
    end else if (ce) begin
      tx_cnt_q <= (tx_st_q == uartm_pkg::ST_IDLE || tx_be) ? 8'h00 : 8'(tx_cnt_q + {7'h00, pre_tick});
      unique case (tx_st_q)
        uartm_pkg::ST_IDLE: if (tx_pop) begin
          tx_st_q   <= uartm_pkg::ST_START;
          tx_line_q <= 1'b0;  // see R01
          tx_sh_q   <= order(fifo_out_data, msb_1st, nb8);
          tx_par_q  <= par_bit(fifo_out_data, nb8, psel);
        end
        uartm_pkg::ST_START: if (tx_be) begin
          tx_st_q   <= uartm_pkg::ST_DATA;
          tx_line_q <= tx_sh_q[0];
          tx_sh_q   <= tx_sh_q >> 1;
          tx_bit_q  <= 4'h1;
        end
        uartm_pkg::ST_DATA: if (tx_be) begin
          if (tx_bit_q != nbits) begin
            tx_line_q <= tx_sh_q[0];
            tx_sh_q   <= tx_sh_q >> 1;
            tx_bit_q  <= 4'(tx_bit_q + 4'h1);
          end else if (par_en) begin
            tx_st_q   <= uartm_pkg::ST_PAR;  // see R13
            tx_line_q <= tx_par_q;
          end else begin
            tx_st_q   <= uartm_pkg::ST_STOP;
            tx_line_q <= 1'b1;
            tx_sb_q   <= 1'b0;
          end
        end
        uartm_pkg::ST_PAR: if (tx_be) begin
          tx_st_q   <= uartm_pkg::ST_STOP;
          tx_line_q <= 1'b1;
          tx_sb_q   <= 1'b0;
        end
        uartm_pkg::ST_STOP: if (tx_be) begin
          if (two_stop && !tx_sb_q) tx_sb_q <= 1'b1;  // see R13
          else tx_st_q <= uartm_pkg::ST_IDLE;
        end
        default: tx_st_q <= uartm_pkg::ST_IDLE;
      endcase
    end
  end

  // Receive engine runs independently of the transmitter.
  always_ff @(posedge clk) begin
    if (reset || (ce && !rx_on)) begin
      rx_st_q   <= uartm_pkg::ST_IDLE;
      rx_cnt_q  <= 8'h00;
      rx_bit_q  <= 4'h0;
      rx_sh_q   <= 8'h00;
      rx_pbad_q <= 1'b0;
    end else if (ce) begin  // see R02
      rx_cnt_q <= (rx_st_q == uartm_pkg::ST_IDLE || rx_be) ? 8'h00 : 8'(rx_cnt_q + {7'h00, pre_tick});
      unique case (rx_st_q)
        uartm_pkg::ST_IDLE: if (!rin) rx_st_q <= uartm_pkg::ST_START;
        uartm_pkg::ST_START: if (rx_be) begin
          rx_st_q   <= rin ? uartm_pkg::ST_IDLE : uartm_pkg::ST_DATA;  // see R01
          rx_bit_q  <= 4'h0;
          rx_pbad_q <= 1'b0;
        end
        uartm_pkg::ST_DATA: if (rx_be) begin
          rx_sh_q  <= {rin, rx_sh_q[7:1]};
          rx_bit_q <= 4'(rx_bit_q + 4'h1);
          if (rx_bit_q == 4'(nbits - 4'h1)) begin
            rx_st_q <= par_en ? uartm_pkg::ST_PAR : uartm_pkg::ST_STOP;
          end
        end
        uartm_pkg::ST_PAR: if (rx_be) begin
          rx_pbad_q <= rin != par_bit(rx_word, nb8, psel);
          rx_st_q   <= uartm_pkg::ST_STOP;
        end
        uartm_pkg::ST_STOP: if (rx_be) rx_st_q <= uartm_pkg::ST_IDLE;
        default: rx_st_q <= uartm_pkg::ST_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  start_bit_low_a: assert property (ce && tx_pop |=> tx_line_q == 1'b0 && tx_st_q == uartm_pkg::ST_START)  // see R01
    else $error("start bit not driven low");
  tx_gate_a: assert property (ce && !tx_on |=> tx_st_q == uartm_pkg::ST_IDLE && tx_line_q)  // see R06
    else $error("transmitter active while disabled");
  rx_gate_a: assert property (ce && !rx_on |=> rx_st_q == uartm_pkg::ST_IDLE)  // see R07
    else $error("receiver active while disabled");
  txbuf_start_a: assert property (ce && wr_txbuf && tx_on && !fifo_out_valid && tx_st_q == uartm_pkg::ST_IDLE
    ##1 ce && tx_on |=> tx_st_q == uartm_pkg::ST_START)  // see R08
    else $error("buffer write did not start a frame");
  stop_level_a: assert property (tx_st_q == uartm_pkg::ST_STOP |-> tx_line_q)  // see R13
    else $error("stop bit not at idle level");
  parity_slot_a: assert property (tx_st_q == uartm_pkg::ST_PAR |-> tx_line_q == tx_par_q && par_en)  // see R13
    else $error("parity bit wrong");
  baud_count_a: assert property (tx_st_q != uartm_pkg::ST_IDLE && baud_q != 8'h00 |-> tx_cnt_q <= baud_m1)  // see R03
    else $error("bit counter past divisor");
  dir_read_a: assert property (bus_rd && ce && bus_addr == uartm_pkg::ADDR_PIN_DIR
    |=> bus_rdata[7:4] == uartm_pkg::PIN_DIR_HI && bus_rdata[3:0] == $past(dir_q))  // see R11
    else $error("direction register read wrong");
  bit_write_a: assert property (ce && wr_dir |=> dir_q == 4'(merge({4'h0, $past(dir_q)}, $past(bus_wdata), $past(bus_wmask))))  // see R12
    else $error("masked direction write wrong");
  dir_oe_a: assert property (ce ##1 ce |-> pin_oe == ~$past(dir_q))  // see R11
    else $error("buffer enable does not follow direction");

  duplex_c: cover property (tx_st_q == uartm_pkg::ST_DATA && rx_st_q == uartm_pkg::ST_DATA);
  rx_done_c: cover property (rx_store && !rx_bad);
  fifo_full_c: cover property (!fifo_in_ready && tx_st_q != uartm_pkg::ST_IDLE);
  two_stop_c: cover property (tx_st_q == uartm_pkg::ST_STOP && tx_sb_q);
endmodule
`default_nettype wire

// file: testbench/uartm_remote.sv
// Remote serial device: decodes frames from the channel's output pin and sends frames to its input pin.
`timescale 1ns/1ns
`default_nettype none
module uartm_remote #(
  parameter int T = 16
) (
  input  wire logic       clk,
  input  wire logic       line_in,
  output logic            line_out,
  input  wire logic [3:0] nbits,
  input  wire logic       msb_first,
  input  wire logic [1:0] par,
  input  wire logic       two_stop,
  input  wire logic       inv,
  input  wire logic       listen
);
  logic [7:0] rx_q[$];
  logic       rxp_q[$];
  logic       rxs_q[$];
  // The line counts as idle while the bench reconfigures the channel, so pin changes there start no frame.
  wire logic  ln = listen ? (line_in ^ inv) : 1'b1;
  initial line_out = 1'b1;
  initial begin : rcv
    logic [7:0] d;
    logic       p;
    logic       s;
    forever begin
      @(posedge clk iff ln === 1'b0);
      repeat (T / 2) @(posedge clk);
      if (ln !== 1'b0) continue;
      d = 8'h00;
      p = 1'b0;
      for (int i = 0; i < nbits; i++) begin
        repeat (T) @(posedge clk);
        if (msb_first) d = {d[6:0], ln};
        else d[i] = ln;
      end
      if (par != 2'h0) begin
        repeat (T) @(posedge clk);
        p = ln;
      end
      repeat (T) @(posedge clk);
      s = (ln === 1'b1);
      if (two_stop) begin
        repeat (T) @(posedge clk);
        s = s & (ln === 1'b1);
      end
      rx_q.push_back(d);
      rxp_q.push_back(p);
      rxs_q.push_back(s);
    end
  end
  task automatic send(input logic [7:0] d, input logic pb, input logic stopv);
    line_out <= 1'b0;
    repeat (T) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      line_out <= msb_first ? d[nbits-1-i] : d[i];
      repeat (T) @(posedge clk);
    end
    if (par != 2'h0) begin
      line_out <= pb;
      repeat (T) @(posedge clk);
    end
    line_out <= stopv;
    repeat (T) @(posedge clk);
    line_out <= 1'b1;
    repeat (T) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_uartm_top.sv
// Self-checking bench of the UART channel: register access, pin direction and serial traffic.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("unexpected %s: expected %0h, seen %0h", nm, e, g); \
  end \
end
module tb_uartm_top;
  localparam int          T     = 16;
  localparam logic [15:0] DIR   = uartm_pkg::ADDR_PIN_DIR;
  localparam logic [15:0] LATCH = uartm_pkg::ADDR_PIN_LATCH;
  localparam logic [15:0] MODE  = uartm_pkg::ADDR_MODE;
  localparam logic [15:0] RXB   = uartm_pkg::ADDR_RXBUF;
  localparam logic [15:0] ERR   = uartm_pkg::ADDR_RXERR;
  localparam logic [15:0] TXS   = uartm_pkg::ADDR_TXSTAT;
  localparam logic [15:0] TXB   = uartm_pkg::ADDR_TXBUF;
  localparam logic [15:0] RA [10] = '{DIR, LATCH, MODE, uartm_pkg::ADDR_CKSEL, uartm_pkg::ADDR_BAUD,
                                      uartm_pkg::ADDR_CTRL, RXB, ERR, TXS, 16'hff00};
  localparam logic [7:0]  RV [10] = '{8'hff, 8'h00, 8'h01, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  localparam logic [4:0]  MF [4]  = '{5'h04, 5'h0e, 5'h10, 5'h1d};
  localparam logic [1:0]  CT [4]  = '{2'h0, 2'h2, 2'h0, 2'h1};
  localparam logic [7:0]  D [4]   = '{8'hc3, 8'h96, 8'hda, 8'h81};
  logic        clk;
  logic        reset;
  logic        ce;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic [7:0]  bus_wmask;
  logic        bus_wr;
  logic        bus_rd;
  logic [7:0]  bus_rdata;
  logic [3:0]  pin_in;
  logic [3:0]  pin_out;
  logic [3:0]  pin_oe;
  logic        rem_tx;
  logic [3:0]  nbits;
  logic        msb_first;
  logic [1:0]  par;
  logic        two_stop;
  logic        inv;
  logic        listen;
  logic [7:0]  v;
  int          n_fail;
  int          num_checks;
  // Pins the channel does not drive are pulled up; pin 3 carries the remote device's output.
  assign pin_in = {rem_tx, (pin_out[2:0] & pin_oe[2:0]) | ~pin_oe[2:0]};
  uartm_top DUT (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_wmask (bus_wmask),
    .bus_wr    (bus_wr),
    .bus_rd    (bus_rd),
    .bus_rdata (bus_rdata),
    .pin_in    (pin_in),
    .pin_out   (pin_out),
    .pin_oe    (pin_oe)
  );
  uartm_remote #(.T(T)) rem (
    .clk       (clk),
    .line_in   (pin_in[2]),
    .line_out  (rem_tx),
    .nbits     (nbits),
    .msb_first (msb_first),
    .par       (par),
    .two_stop  (two_stop),
    .inv       (inv),
    .listen    (listen)
  );
  function automatic logic [7:0] msk();
    return (nbits == 4'h8) ? 8'hff : 8'h7f;
  endfunction
  function automatic logic pbit(input logic [7:0] d);
    if (par == 2'h1) return 1'b0;
    if (par == 2'h2) return ~^(d & msk());
    return ^(d & msk());
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
    @(posedge clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wmask <= m;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    @(posedge clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    q = bus_rdata;
  endtask
  task automatic cfg(input logic [4:0] mf, input logic [1:0] ct, input logic [2:0] ck, input logic [1:0] en);
    listen = 1'b0;
    wr(MODE, 8'h00);
    wr(uartm_pkg::ADDR_CKSEL, {5'h00, ck});
    wr(uartm_pkg::ADDR_BAUD, 8'h10 >> ck);
    wr(MODE, {3'h0, mf});
    wr(uartm_pkg::ADDR_CTRL, {6'h00, ct});
    wr(MODE, {3'h4, mf});
    wr(MODE, {1'b1, en, mf});
    nbits = mf[2] ? 4'h8 : 4'h7;
    two_stop = mf[1];
    par = mf[4:3];
    msb_first = ct[1];
    inv = ct[0];
    repeat (4) @(posedge clk);
    #1;
    listen = 1'b1;
  endtask
  task automatic snd(input logic [7:0] d, input logic perr, input logic stopv);
    rem.send(d & msk(), perr ^ pbit(d), stopv);
  endtask
  task automatic chk_tx(input logic [7:0] d);
    logic [7:0] g;
    logic       p;
    logic       s;
    for (int i = 0; i < 30 * T && rem.rx_q.size() == 0; i++) @(posedge clk);
    `CHK("tx frame seen", 1'b1, rem.rx_q.size() != 0)
    if (rem.rx_q.size() != 0) begin
      g = rem.rx_q.pop_front();
      p = rem.rxp_q.pop_front();
      s = rem.rxs_q.pop_front();
      `CHK("tx data", d & msk(), g)
      if (par != 2'h0) `CHK("tx parity", pbit(d), p)
      `CHK("tx stop", 1'b1, s)
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {reset, ce, bus_wr, bus_rd, bus_addr, bus_wdata, bus_wmask} = {2'h3, 2'h0, 16'h0000, 8'h00, 8'hff};
    {nbits, msb_first, par, two_stop, inv, listen, n_fail, num_checks} = {4'h8, 6'h00, 32'd0, 32'd0};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    foreach (RA[i]) begin
      rd(RA[i], v);
      `CHK("reset value", RV[i], v)
    end
    @(posedge clk);
    #1;
    `CHK("rdata after read", 8'h00, bus_rdata)
    `CHK("pin_oe", 4'h0, pin_oe)
    $display("test done: reset values");
    wr(DIR, 8'h00, 8'h04);
    rd(DIR, v);
    `CHK("dir bit write", 8'hfb, v)
    `CHK("pin_oe", 4'h4, pin_oe)
    wr(DIR, 8'h08);
    rd(DIR, v);
    `CHK("dir byte write", 8'hf8, v)
    `CHK("pin_oe", 4'h7, pin_oe)
    wr(DIR, 8'h0b);
    wr(LATCH, 8'hff, 8'h04);
    repeat (3) @(posedge clk);
    #1;
    `CHK("tx pin idle", 1'b1, pin_out[2])
    // A write while the clock enable is low must leave the register untouched.
    ce <= 1'b0;
    wr(DIR, 8'h0f);
    ce <= 1'b1;
    rd(DIR, v);
    `CHK("write while frozen", 8'hfb, v)
    $display("test done: pin direction");
    cfg(5'h04, 2'h0, 3'h0, 2'h1);
    wr(TXB, 8'h77);
    repeat (20 * T) @(posedge clk);
    `CHK("frames while tx off", 0, rem.rx_q.size())
    snd(8'h3c, 1'b0, 1'b1);
    rd(RXB, v);
    `CHK("rx buffer", 8'h3c, v)
    cfg(5'h04, 2'h0, 3'h0, 2'h2);
    snd(8'h99, 1'b0, 1'b1);
    rd(RXB, v);
    `CHK("rx while off", 8'h3c, v)
    $display("test done: enables");
    for (int i = 0; i < 4; i++) begin
      cfg(MF[i], CT[i], i[2:0] & 3'h1, 2'h3);
      `CHK("idle level", ~CT[i][0], pin_out[2])
      fork
        wr(TXB, D[i]);
        snd(~D[i], 1'b0, 1'b1);
      join
      chk_tx(D[i]);
      rd(RXB, v);
      `CHK("rx data", ~D[i] & msk(), v & msk())
      rd(ERR, v);
      `CHK("rx errors", 8'h00, v)
    end
    snd(8'h81, 1'b1, 1'b1);
    rd(ERR, v);
    `CHK("parity error", 8'h04, v)
    rd(RXB, v);
    `CHK("bad char kept", 8'h81, v)
    $display("test done: frame formats");
    cfg(5'h04, 2'h0, 3'h0, 2'h3);
    wr(TXB, 8'h11);
    wr(TXB, 8'h22);
    wr(TXB, 8'h33);
    rd(TXS, v);
    `CHK("tx busy and full", 8'h03, v)
    wr(TXB, 8'h44);
    chk_tx(8'h11);
    chk_tx(8'h22);
    chk_tx(8'h33);
    repeat (15 * T) @(posedge clk);
    `CHK("frames after full", 0, rem.rx_q.size())
    rd(TXS, v);
    `CHK("tx status idle", 8'h00, v)
    $display("test done: transmit buffer");
    snd(8'h55, 1'b0, 1'b0);
    rd(ERR, v);
    `CHK("framing error", 8'h02, v)
    rd(ERR, v);
    `CHK("errors cleared", 8'h00, v)
    rd(RXB, v);
    `CHK("bad char not stored", 8'h81, v)
    snd(8'h12, 1'b0, 1'b1);
    snd(8'h34, 1'b0, 1'b1);
    rd(ERR, v);
    `CHK("overrun", 8'h01, v)
    rd(RXB, v);
    `CHK("overrun data", 8'h34, v)
    $display("test done: receive errors");
    report_and_stop();
  end
endmodule
`default_nettype wire
